/* File: rtl/uhr_port_router.sv */
// Packet router and root hub port ownership for the USB host functions.
`timescale 1ns/1ps
`default_nettype none

module uhr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } uhr_fifo_st_t;

  uhr_fifo_st_t st;
  uhr_fifo_st_t next_st;
  logic         push;
  logic         pop;

  assign in_ready_out  = (st.cnt != CW'(DEPTH));
  assign out_valid_out = (st.cnt != '0);
  assign out_data_out  = st.mem[st.rd];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data_in;
      next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: next_st.cnt = st.cnt + 1'b1;
      2'b01: next_st.cnt = st.cnt - 1'b1;
      default: next_st.cnt = st.cnt;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  fifo_bound_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    st.cnt <= CW'(DEPTH)) else $error("FIFO count above depth.");
endmodule

module uhr_port_router #(
  parameter int NP    = uhr_pkg::UHR_NPORTS,
  parameter int DEPTH = uhr_pkg::UHR_FIFO_DEPTH
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          rstn_in,
  input  wire logic                          enum_load_in,
  input  wire uhr_pkg::uhr_enum_t            enum_in,
  input  wire uhr_pkg::uhr_win_t [2:0]       mem_win_in,
  input  wire uhr_pkg::uhr_win_t [2:0]       io_win_in,
  input  wire logic                          tlp_valid_in,
  input  wire uhr_pkg::uhr_tlp_t             tlp_in,
  output logic                               tlp_ready_out,
  output logic                               route_valid_out,
  output uhr_pkg::uhr_route_t                route_out,
  input  wire logic                          route_ready_in,
  input  wire logic [NP-1:0]                 port_attach_in,
  input  wire logic [NP-1:0]                 port_hs_in,
  output uhr_pkg::uhr_own_t [NP-1:0]         port_owner_out,
  output logic [2:0]                         max_payload_code_out
);
  import uhr_pkg::*;

  localparam int RW = $bits(uhr_route_t);

  typedef struct packed {
    uhr_enum_t             ids;
    logic [NP-1:0]         att_s1;
    logic [NP-1:0]         att_s2;
    logic [NP-1:0]         hs_s1;
    logic [NP-1:0]         hs_s2;
    uhr_own_t [NP-1:0]     owner;
  } uhr_top_st_t;

  uhr_top_st_t       st;
  uhr_top_st_t       next_st;
  uhr_route_t        dec;
  uhr_own_t [NP-1:0] want;
  logic [RW-1:0]     fifo_out;

  function automatic logic win_hit(input logic [31:0] a, input uhr_win_t w);
    return w.en && ((a & w.mask) == (w.base & w.mask));
  endfunction

  // Fixed priority keeps a single claimant even if software programs overlapping windows.
  function automatic uhr_tgt_t win_dec(input logic [31:0] a, input uhr_win_t [2:0] w);
    uhr_tgt_t t;
    t = UHR_TGT_NONE;
    if (win_hit(a, w[UHR_FN_OHCI0])) begin
      t = UHR_TGT_OHCI0;
    end else if (win_hit(a, w[UHR_FN_OHCI1])) begin
      t = UHR_TGT_OHCI1;
    end else if (win_hit(a, w[UHR_FN_EHCI])) begin
      t = UHR_TGT_EHCI;
    end
    return t;
  endfunction

  function automatic uhr_tgt_t id_dec(input uhr_id_t d, input uhr_enum_t e);
    uhr_tgt_t t;
    t = UHR_TGT_NONE;
    if (d == e.up) begin
      t = UHR_TGT_UPORT;
    end else if (d == e.dn) begin
      t = UHR_TGT_DPORT;
    end else if (d.bus == e.usb_bus && d.dev == e.usb_dev) begin
      if (d.fn == UHR_FN_OHCI0) begin
        t = UHR_TGT_OHCI0;
      end else if (d.fn == UHR_FN_OHCI1) begin
        t = UHR_TGT_OHCI1;
      end else if (d.fn == UHR_FN_EHCI) begin
        t = UHR_TGT_EHCI;
      end
    end
    return t;
  endfunction

  function automatic logic too_long(input uhr_tlp_t p);
    return p.has_data &&
      (p.len_dw == UHR_LEN_1024_DW || p.len_dw > UHR_MAX_PAYLOAD_DW);
  endfunction

  function automatic uhr_own_t want_fn(input logic att, input logic hs, input int idx);
    uhr_own_t o;
    o = UHR_OWN_NONE;
    if (att && hs) begin
      o = UHR_OWN_EHCI;
    end else if (att && idx < UHR_OHCI0_PORTS) begin
      o = UHR_OWN_OHCI0;
    end else if (att) begin
      o = UHR_OWN_OHCI1;
    end
    return o;
  endfunction

  always_comb begin
    dec          = '0;
    dec.tlp      = tlp_in;
    dec.oversize = too_long(tlp_in);
    case (tlp_in.kind)
      UHR_KIND_MEM: dec.tgt = win_dec(tlp_in.addr, mem_win_in);
      UHR_KIND_IO:  dec.tgt = win_dec(tlp_in.addr, io_win_in);
      default:      dec.tgt = id_dec(tlp_in.dest, st.ids);
    endcase
    if (dec.oversize) begin
      dec.tgt = UHR_TGT_NONE;
    end
  end

  // The FIFO ready goes straight back to the packet source, so a stalled sink holds the link.
  uhr_fifo #(
    .WIDTH (RW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (tlp_valid_in),
    .in_data_in    (dec),
    .in_ready_out  (tlp_ready_out),
    .out_valid_out (route_valid_out),
    .out_data_out  (fifo_out),
    .out_ready_in  (route_ready_in)
  );

  assign route_out            = uhr_route_t'(fifo_out);
  assign port_owner_out       = st.owner;
  assign max_payload_code_out = UHR_MPS_CODE;

  for (genvar i = 0; i < NP; i++) begin : g_want
    assign want[i] = want_fn(st.att_s2[i], st.hs_s2[i], i);
  end

  always_comb begin
    next_st        = st;
    next_st.att_s1 = port_attach_in;
    next_st.att_s2 = st.att_s1;
    next_st.hs_s1  = port_hs_in;
    next_st.hs_s2  = st.hs_s1;
    if (enum_load_in) begin
      next_st.ids = enum_in;
    end
    // A speed change costs one idle cycle so two controllers never drive a port at once.
    for (int i = 0; i < NP; i++) begin
      if (st.owner[i] != want[i] && st.owner[i] != UHR_OWN_NONE) begin
        next_st.owner[i] = UHR_OWN_NONE;
      end else begin
        next_st.owner[i] = want[i];
      end
    end
  end

  // This block holds no sticky state, so reset clears all of it.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  sequence usb_cfg_s(logic [2:0] f);
    tlp_valid_in && tlp_in.kind == UHR_KIND_CFG && !too_long(tlp_in) &&
      tlp_in.dest.bus == st.ids.usb_bus && tlp_in.dest.dev == st.ids.usb_dev &&
      tlp_in.dest.fn == f && tlp_in.dest != st.ids.up && tlp_in.dest != st.ids.dn;
  endsequence

  ehci_fn_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    usb_cfg_s(UHR_FN_EHCI) |-> dec.tgt == UHR_TGT_EHCI)
    else $error("Function 2 not routed to EHCI.");

  ohci_fn_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    usb_cfg_s(UHR_FN_OHCI0) or usb_cfg_s(UHR_FN_OHCI1) |->
      dec.tgt == ((tlp_in.dest.fn == UHR_FN_OHCI0) ? UHR_TGT_OHCI0 : UHR_TGT_OHCI1))
    else $error("Function 0 or 1 not routed to its OHCI.");

  common_dev_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    tlp_valid_in && tlp_in.kind != UHR_KIND_MEM && tlp_in.kind != UHR_KIND_IO &&
      tlp_in.dest.dev != st.ids.usb_dev |->
      dec.tgt != UHR_TGT_OHCI0 && dec.tgt != UHR_TGT_OHCI1 && dec.tgt != UHR_TGT_EHCI)
    else $error("Function claimed under a foreign device number.");

  win_excl_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    tlp_valid_in && tlp_in.kind == UHR_KIND_MEM && dec.tgt == UHR_TGT_OHCI1 |->
      !win_hit(tlp_in.addr, mem_win_in[UHR_FN_OHCI0]) &&
      win_hit(tlp_in.addr, mem_win_in[UHR_FN_OHCI1]))
    else $error("Memory window claimed twice.");

  oversize_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    tlp_valid_in && tlp_in.has_data && tlp_in.len_dw > UHR_MAX_PAYLOAD_DW |->
      dec.oversize && dec.tgt == UHR_TGT_NONE)
    else $error("Oversized payload was routed.");

  route_pass_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    tlp_valid_in && tlp_ready_out && !route_valid_out |=>
      route_valid_out && route_out == $past(dec))
    else $error("Routed packet did not reach the output.");

  ids_hold_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !enum_load_in |=> $stable(st.ids))
    else $error("Enumerated IDs changed without a load.");

  ids_load_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    enum_load_in |=> st.ids == $past(enum_in))
    else $error("Enumerated IDs not captured.");

  for (genvar i = 0; i < NP; i++) begin : g_port_chk
    sequence hs_steady_s;
      (st.att_s2[i] && st.hs_s2[i]) [*3];
    endsequence
    sequence fs_steady_s;
      (st.att_s2[i] && !st.hs_s2[i]) [*3];
    endsequence

    hs_owner_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      hs_steady_s |-> st.owner[i] == UHR_OWN_EHCI)
      else $error("High-speed port not given to EHCI.");

    if (i < UHR_OHCI0_PORTS) begin : g_lo
      ohci0_owner_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        fs_steady_s |-> st.owner[i] == UHR_OWN_OHCI0)
        else $error("Port 1 or 2 not given to OHCI0.");
    end else begin : g_hi
      ohci1_owner_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        fs_steady_s |-> st.owner[i] == UHR_OWN_OHCI1)
        else $error("Port 3 or 4 not given to OHCI1.");
    end

    handover_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      $changed(st.owner[i]) && $past(st.owner[i]) != UHR_OWN_NONE |->
        st.owner[i] == UHR_OWN_NONE)
      else $error("Port passed between controllers without release.");
  end
endmodule

`default_nettype wire

/* File: rtl/uhr_pkg.sv */
// Types and constants shared by the USB host function port router.
// Notes on behaviour
// - EHCI controller answers as function 2.
// - Two OHCI controllers answer as functions 0, 1.
// - All three functions share one device number.
// - High-speed port of any index goes to EHCI.
// - Full/low-speed ports 1, 2 go to OHCI0.
// - Full/low-speed ports 3, 4 go to OHCI1.
// - Four shared ports, each handling all speeds.
// - Each packet routed to exactly one target.
// - Address windows claimed by one function only.
// - Hold enumerated IDs, match ID-routed packets.
// - Payload limited to 256 bytes, advertised so.
// - Controller registers reached by memory decode.
// - Reset initializes all non-sticky state.
package uhr_pkg;

  localparam int         UHR_NPORTS            = 4;
  localparam int         UHR_OHCI0_PORTS       = 2;
  localparam int         UHR_FIFO_DEPTH        = 8;
  localparam int         UHR_NFUNC             = 3;
  localparam logic [2:0] UHR_FN_OHCI0          = 3'h0;
  localparam logic [2:0] UHR_FN_OHCI1          = 3'h1;
  localparam logic [2:0] UHR_FN_EHCI           = 3'h2;
  localparam int         UHR_MAX_PAYLOAD_BYTES = 256;
  localparam logic [9:0] UHR_MAX_PAYLOAD_DW    = 10'(UHR_MAX_PAYLOAD_BYTES / 4);
  localparam logic [9:0] UHR_LEN_1024_DW       = 10'h000;
  localparam logic [2:0] UHR_MPS_CODE          = 3'h1;

  typedef enum logic [2:0] {
    UHR_TGT_OHCI0 = 3'b000,
    UHR_TGT_OHCI1 = 3'b001,
    UHR_TGT_EHCI  = 3'b010,
    UHR_TGT_UPORT = 3'b011,
    UHR_TGT_DPORT = 3'b100,
    UHR_TGT_NONE  = 3'b111
  } uhr_tgt_t;

  typedef enum logic [1:0] {
    UHR_KIND_MEM = 2'b00,
    UHR_KIND_IO  = 2'b01,
    UHR_KIND_CFG = 2'b10,
    UHR_KIND_CPL = 2'b11
  } uhr_kind_t;

  typedef enum logic [1:0] {
    UHR_OWN_NONE  = 2'b00,
    UHR_OWN_EHCI  = 2'b01,
    UHR_OWN_OHCI0 = 2'b10,
    UHR_OWN_OHCI1 = 2'b11
  } uhr_own_t;

  typedef struct packed {
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] fn;
  } uhr_id_t;

  typedef struct packed {
    uhr_id_t    up;
    uhr_id_t    dn;
    logic [7:0] usb_bus;
    logic [4:0] usb_dev;
  } uhr_enum_t;

  typedef struct packed {
    logic        en;
    logic [31:0] base;
    logic [31:0] mask;
  } uhr_win_t;

  typedef struct packed {
    uhr_kind_t   kind;
    logic        has_data;
    logic [31:0] addr;
    uhr_id_t     dest;
    logic [9:0]  len_dw;
    logic [7:0]  tag;
  } uhr_tlp_t;

  typedef struct packed {
    uhr_tlp_t tlp;
    uhr_tgt_t tgt;
    logic     oversize;
  } uhr_route_t;

endpackage

/* File: test/uhr_route_sink.sv */
// Partner model that takes routed headers from the router and can stall.
`timescale 1ns/1ps
`default_nettype none
module uhr_route_sink (
  input  wire logic            core_clk_in,
  input  wire logic            rstn_in,
  input  wire logic            stall_in,
  input  wire logic            route_valid_in,
  input  wire uhr_pkg::uhr_route_t route_in,
  output logic                 route_ready_out
);
  import uhr_pkg::*;
  uhr_route_t seen[$];
  // Ready follows stall one rising edge later, so it never races the bench's stall change.
  always @(posedge core_clk_in) begin
    route_ready_out <= !stall_in;
  end
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seen.delete();
    end else if (route_valid_in && route_ready_out) begin
      seen.push_back(route_in);
    end
  end
endmodule
`default_nettype wire

/* File: test/uhr_port_router_bench.sv */
// Self-checking bench for the USB host function port router.
`timescale 1ns/1ps
`default_nettype none
module uhr_port_router_bench;
  import uhr_pkg::*;
  logic           core_clk_in;
  logic           rstn_in;
  logic           enum_load_in;
  uhr_enum_t      enum_in;
  uhr_win_t [2:0] mem_win_in;
  uhr_win_t [2:0] io_win_in;
  logic           tlp_valid_in;
  uhr_tlp_t       tlp_in;
  logic           tlp_ready_out;
  logic           route_valid_out;
  uhr_route_t     route_out;
  logic           route_ready_in;
  logic [3:0]     port_attach_in;
  logic [3:0]     port_hs_in;
  uhr_own_t [3:0] port_owner_out;
  logic [2:0]     max_payload_code_out;
  logic           stall;
  int             miscompares;
  int             comparisons;
  int             cycles;

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  uhr_port_router #(.NP(4), .DEPTH(8)) dut (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .enum_load_in(enum_load_in),
    .enum_in(enum_in), .mem_win_in(mem_win_in), .io_win_in(io_win_in),
    .tlp_valid_in(tlp_valid_in), .tlp_in(tlp_in), .tlp_ready_out(tlp_ready_out),
    .route_valid_out(route_valid_out), .route_out(route_out),
    .route_ready_in(route_ready_in), .port_attach_in(port_attach_in),
    .port_hs_in(port_hs_in), .port_owner_out(port_owner_out),
    .max_payload_code_out(max_payload_code_out));

  uhr_route_sink sink (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .stall_in(stall),
    .route_valid_in(route_valid_out), .route_in(route_out),
    .route_ready_out(route_ready_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Leaves valid high on return; the caller sends again or drops it at once.
  task automatic send(input uhr_kind_t k, input logic [31:0] a, input uhr_id_t d,
                      input logic [9:0] l, input logic [7:0] g, input logic h = 1'b1);
    int n;
    n = 0;
    tlp_in = uhr_tlp_t'{k, h, a, d, l, g};
    tlp_valid_in = 1'b1;
    while (tlp_ready_out !== 1'b1 && n < 100) begin
      @(negedge core_clk_in);
      n++;
    end
    check(32'(n < 100), 32'h1);
    @(negedge core_clk_in);
  endtask

  task automatic pull(input logic [7:0] g, input uhr_tgt_t t, input logic o);
    uhr_route_t r;
    int n;
    n = 0;
    while (sink.seen.size() == 0 && n < 100) begin
      @(negedge core_clk_in);
      n++;
    end
    if (sink.seen.size() == 0) begin
      check(32'h0, 32'h1);
    end else begin
      r = sink.seen.pop_front();
      check({20'h0, r.oversize, r.tgt, r.tlp.tag}, {20'h0, o, t, g});
    end
  endtask

  task automatic scen_addr();
    for (int f = 0; f < 3; f++) begin
      mem_win_in[f] = uhr_win_t'{1'b1, 32'(f + 1) << 28, 32'hffff_0000};
      io_win_in[f] = uhr_win_t'{1'b1, 32'(f + 1) << 8, 32'hffff_ff00};
    end
    for (int f = 0; f < 4; f++) begin
      send(UHR_KIND_MEM, (32'(f + 1) << 28) | 32'h44, '0, 10'h1, 8'(f));
      send(UHR_KIND_IO, (32'(f + 1) << 8) | 32'h4, '0, 10'h1, 8'(f + 8));
    end
    mem_win_in[2].en = 1'b0;
    send(UHR_KIND_MEM, 32'h3000_0044, '0, 10'h1, 8'h10);
    // Overlapping windows: the lower function keeps the claim.
    mem_win_in[1].base = 32'h1000_0000;
    send(UHR_KIND_MEM, 32'h1000_0010, '0, 10'h1, 8'h11);
    mem_win_in[1].base = 32'h2000_0000;
    tlp_valid_in = 1'b0;
    for (int f = 0; f < 4; f++) begin
      pull(8'(f), f < 3 ? uhr_tgt_t'(f) : UHR_TGT_NONE, 1'b0);
      pull(8'(f + 8), f < 3 ? uhr_tgt_t'(f) : UHR_TGT_NONE, 1'b0);
    end
    pull(8'h10, UHR_TGT_NONE, 1'b0);
    pull(8'h11, UHR_TGT_OHCI0, 1'b0);
  endtask

  task automatic scen_id();
    uhr_tgt_t t;
    enum_in = uhr_enum_t'{'{8'h01, 5'h00, 3'h0}, '{8'h02, 5'h00, 3'h0}, 8'h03, 5'h04};
    enum_load_in = 1'b1;
    @(negedge core_clk_in);
    enum_load_in = 1'b0;
    send(UHR_KIND_CFG, '0, enum_in.up, 10'h1, 8'h20);
    send(UHR_KIND_CPL, '0, enum_in.dn, 10'h1, 8'h21);
    for (int f = 0; f < 4; f++) begin
      send(UHR_KIND_CFG, '0, '{8'h03, f < 3 ? 5'h04 : 5'h05, 3'(f % 3)}, 10'h1, 8'(f + 34));
    end
    tlp_valid_in = 1'b0;
    pull(8'h20, UHR_TGT_UPORT, 1'b0);
    pull(8'h21, UHR_TGT_DPORT, 1'b0);
    for (int f = 0; f < 4; f++) begin
      t = f < 3 ? uhr_tgt_t'(f) : UHR_TGT_NONE;
      pull(8'(f + 34), t, 1'b0);
    end
  endtask

  task automatic scen_size();
    send(UHR_KIND_MEM, 32'h1000_0000, '0, 10'h040, 8'h30);
    send(UHR_KIND_MEM, 32'h1000_0000, '0, 10'h041, 8'h31);
    send(UHR_KIND_MEM, 32'h1000_0000, '0, 10'h000, 8'h32);
    send(UHR_KIND_MEM, 32'h1000_0000, '0, 10'h000, 8'h33, 1'b0);
    tlp_valid_in = 1'b0;
    pull(8'h30, UHR_TGT_OHCI0, 1'b0);
    pull(8'h31, UHR_TGT_NONE, 1'b1);
    pull(8'h32, UHR_TGT_NONE, 1'b1);
    pull(8'h33, UHR_TGT_OHCI0, 1'b0);
  endtask

  task automatic scen_fifo();
    stall = 1'b1;
    for (int i = 0; i < 8; i++) begin
      send(UHR_KIND_MEM, 32'h2000_0000, '0, 10'h1, 8'(i + 64));
    end
    check({31'h0, tlp_ready_out}, 32'h0);
    tlp_valid_in = 1'b0;
    stall = 1'b0;
    for (int i = 0; i < 8; i++) begin
      pull(8'(i + 64), UHR_TGT_OHCI1, 1'b0);
    end
    stall = 1'b1;
    send(UHR_KIND_MEM, 32'h2000_0000, '0, 10'h1, 8'h50);
    tlp_valid_in = 1'b0;
    rstn_in = 1'b0;
    @(negedge core_clk_in);
    check({30'h0, route_valid_out, tlp_ready_out}, 32'h1);
    rstn_in = 1'b1;
    stall = 1'b0;
  endtask

  task automatic ports();
    uhr_own_t lo;
    for (int i = 0; i < 4; i++) begin
      lo = i < 2 ? UHR_OWN_OHCI0 : UHR_OWN_OHCI1;
      port_attach_in[i] = 1'b1;
      port_hs_in[i] = 1'b1;
      repeat (4) @(negedge core_clk_in);
      check({30'h0, port_owner_out[i]}, {30'h0, UHR_OWN_EHCI});
      port_hs_in[i] = 1'b0;
      repeat (4) @(negedge core_clk_in);
      check({30'h0, port_owner_out[i]}, {30'h0, lo});
    end
    check(32'(port_owner_out), 32'hfa);
    port_attach_in = '0;
    repeat (4) @(negedge core_clk_in);
    check(32'(port_owner_out), 32'h0);
  endtask

  // A hang is cut short here well past the under two hundred cycles the run needs.
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    rstn_in = 1'b0;
    enum_load_in = 1'b0;
    enum_in = '0;
    mem_win_in = '0;
    io_win_in = '0;
    tlp_valid_in = 1'b0;
    tlp_in = '0;
    port_attach_in = '0;
    port_hs_in = '0;
    stall = 1'b0;
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(negedge core_clk_in);
    check({30'h0, route_valid_out, tlp_ready_out}, 32'h1);
    check(32'(port_owner_out), 32'h0);
    check({29'h0, max_payload_code_out}, 32'h1);
    rstn_in = 1'b1;
    scen_addr();
    scen_id();
    scen_size();
    scen_fifo();
    ports();
    results();
  end
endmodule
`default_nettype wire
